// >>> include/cut_line_params.svh
// constant definitions for the cut line speed and run configuration block
`ifndef CUT_LINE_PARAMS_SVH
`define CUT_LINE_PARAMS_SVH
// =========================================
// switch positions (bit index = switch number - 1)
`define CL_SW_COUNT 7
`define CL_SW_SPEED_A 0
`define CL_SW_SPEED_B 1
`define CL_SW_POS3 2
`define CL_SW_POS4 3
`define CL_SW_POS5 4
`define CL_SW_POS6 5
`define CL_SW_POS7 6
// =========================================
// reset values
`define CL_SW_RESET 7'h00
// =========================================
// timing
`define CL_CLK_MHZ 100
`define CL_ILK_WIN_MS 1000
`define CL_ILK_WIN_CYC (`CL_ILK_WIN_MS * 1000 * `CL_CLK_MHZ)
`endif

// >>> include/cut_line_pkg.sv
// types shared by the cut line configuration block
package cut_line_pkg;
  typedef enum logic [1:0] {
    SPD_SINGLE = 2'b00,
    SPD_FWD_SLOW = 2'b01,
    SPD_FAST_SLOW = 2'b10,
    SPD_INVALID = 2'b11
  } speed_mode_t;
  typedef enum logic [1:0] {
    MT_FLY_BOOST = 2'b00,
    MT_FLY_PLAIN = 2'b01,
    MT_STOP_PER_CUT = 2'b10,
    MT_UNUSED = 2'b11
  } mach_type_t;
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_WAIT_ILK = 2'b01,
    RS_RUN = 2'b10
  } run_state_t;
endpackage : cut_line_pkg

// >>> include/cfg_if.sv
// decoded configuration passed from the switch sampler to its users
`timescale 1ns/1ps
`default_nettype none
interface cfg_if;
  logic valid;
  logic opt_variant;
  cut_line_pkg::speed_mode_t speed_mode;
  cut_line_pkg::mach_type_t mach_type;
  logic remote_mode;
  logic shear_flying;
  logic shear_boost;
  logic shear_two_speed;
  logic manual_shear_block;
  logic single_batch;
  logic punch_flying;
  logic punch_boost;
  logic punch_two_speed;
  modport src (
    output valid, opt_variant, speed_mode, mach_type, remote_mode, shear_flying, shear_boost,
    output shear_two_speed, manual_shear_block, single_batch, punch_flying, punch_boost, punch_two_speed
  );
  modport dst (
    input valid, opt_variant, speed_mode, mach_type, remote_mode, shear_flying, shear_boost,
    input shear_two_speed, manual_shear_block, single_batch, punch_flying, punch_boost, punch_two_speed
  );
endinterface : cfg_if
`default_nettype wire

// >>> rtl/cfg_sample.sv
// switch bank sampler and decoder, frozen after the first edge out of reset
`timescale 1ns/1ps
`default_nettype none
`include "cut_line_params.svh"
module cfg_sample (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`CL_SW_COUNT-1:0] cfg_sw,
  input wire logic opt_strap,
  cfg_if.src cfg
);
  logic [`CL_SW_COUNT-1:0] sw_q;
  logic opt_q;
  logic taken_q;

  // =========================================
  // one-shot capture
  // straps are caught by a clock edge, never by the async reset itself
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_q <= `CL_SW_RESET;
      opt_q <= 1'b0;
      taken_q <= 1'b0;
    end else if (!taken_q) begin
      sw_q <= cfg_sw;
      opt_q <= opt_strap;
      taken_q <= 1'b1;
    end
  end

  // =========================================
  // decode per variant
  assign cfg.valid = taken_q;
  assign cfg.opt_variant = opt_q;
  assign cfg.speed_mode = opt_q ? cut_line_pkg::SPD_SINGLE :
    cut_line_pkg::speed_mode_t'({sw_q[`CL_SW_SPEED_B], sw_q[`CL_SW_SPEED_A]});
  assign cfg.mach_type = cut_line_pkg::mach_type_t'({sw_q[`CL_SW_POS5], sw_q[`CL_SW_POS4]});
  assign cfg.remote_mode = opt_q ? sw_q[`CL_SW_POS4] : sw_q[`CL_SW_POS3];
  assign cfg.shear_flying = opt_q & sw_q[`CL_SW_SPEED_A];
  assign cfg.shear_boost = opt_q & ~sw_q[`CL_SW_SPEED_B];
  assign cfg.shear_two_speed = opt_q & sw_q[`CL_SW_POS3];
  assign cfg.manual_shear_block = ~opt_q & sw_q[`CL_SW_POS6];
  assign cfg.single_batch = ~opt_q & sw_q[`CL_SW_POS7];
  assign cfg.punch_flying = opt_q & sw_q[`CL_SW_POS5];
  assign cfg.punch_boost = opt_q & ~sw_q[`CL_SW_POS6];
  assign cfg.punch_two_speed = opt_q & sw_q[`CL_SW_POS7];

  // =========================================
  // checks
  cfg_frozen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    taken_q ##1 taken_q |-> $stable(sw_q) && $stable(opt_q))
    else $error("configuration changed after capture");
endmodule : cfg_sample
`default_nettype wire

// >>> rtl/run_start.sv
// automatic sequence start: local press with interlock window, or held remote input
`timescale 1ns/1ps
`default_nettype none
module run_start #(
  parameter int unsigned ILK_WIN_CYC = 100000000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  cfg_if.dst cfg,
  input wire logic run_press,
  input wire logic in3_closed,
  input wire logic job_valid,
  input wire logic length_ok,
  input wire logic halt_req,
  input wire logic seq_done,
  output logic running,
  output logic [1:0] state
);
  cut_line_pkg::run_state_t st_q;
  logic [31:0] win_q;
  logic job_ok;
  logic stop;

  assign job_ok = job_valid & length_ok & cfg.valid & (cfg.speed_mode != cut_line_pkg::SPD_INVALID);
  // a local run drops as soon as the interlock opens; a remote run as soon as its input does
  assign stop = halt_req | seq_done | ~in3_closed;
  assign running = (st_q == cut_line_pkg::RS_RUN);
  assign state = st_q;

  // =========================================
  // start sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= cut_line_pkg::RS_IDLE;
    end else begin
      case (st_q)
        cut_line_pkg::RS_IDLE: begin
          if (cfg.remote_mode) begin
            if (in3_closed && job_ok && !halt_req) st_q <= cut_line_pkg::RS_RUN;
          end else if (run_press && job_ok && !halt_req) begin
            st_q <= in3_closed ? cut_line_pkg::RS_RUN : cut_line_pkg::RS_WAIT_ILK;
          end
        end
        cut_line_pkg::RS_WAIT_ILK: begin
          if (cfg.remote_mode || halt_req || !job_ok) st_q <= cut_line_pkg::RS_IDLE;
          else if (in3_closed) st_q <= cut_line_pkg::RS_RUN;
          else if (win_q >= ILK_WIN_CYC - 1) st_q <= cut_line_pkg::RS_IDLE;
        end
        cut_line_pkg::RS_RUN: begin
          if (stop) st_q <= cut_line_pkg::RS_IDLE;
        end
        default: st_q <= cut_line_pkg::RS_IDLE;
      endcase
    end
  end

  // =========================================
  // interlock window count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 32'h0000_0000;
    end else if (st_q == cut_line_pkg::RS_WAIT_ILK) begin
      win_q <= win_q + 32'h0000_0001;
    end else begin
      win_q <= 32'h0000_0000;
    end
  end

  // =========================================
  // checks
  local_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q == cut_line_pkg::RS_IDLE && !cfg.remote_mode && run_press && job_ok && in3_closed && !halt_req
    |=> st_q == cut_line_pkg::RS_RUN)
    else $error("local start with interlock closed did not run");
  start_guard_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q != cut_line_pkg::RS_RUN ##1 st_q == cut_line_pkg::RS_RUN |-> $past(job_ok) && $past(in3_closed))
    else $error("run entered without valid job, length or input 3");
  ilk_window_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q == cut_line_pkg::RS_WAIT_ILK |-> win_q < ILK_WIN_CYC)
    else $error("interlock window overran one second");
  ilk_noauto_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_q == cut_line_pkg::RS_IDLE && !cfg.remote_mode && !run_press |=> st_q == cut_line_pkg::RS_IDLE)
    else $error("interlock closing started the machine");
  remote_panel_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg.remote_mode && st_q == cut_line_pkg::RS_IDLE && !in3_closed |=> st_q == cut_line_pkg::RS_IDLE)
    else $error("remote mode left idle without input 3");
endmodule : run_start
`default_nettype wire

// >>> rtl/cut_line_speed_run_config.sv
// top: switch configuration, run start and speed output logic for a cut-to-length line
`timescale 1ns/1ps
`default_nettype none
`include "cut_line_params.svh"
module cut_line_speed_run_config #(
  parameter int unsigned ILK_WIN_CYC = `CL_ILK_WIN_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`CL_SW_COUNT-1:0] cfg_sw,
  input wire logic opt_strap,
  input wire logic run_press,
  input wire logic in3_closed,
  input wire logic job_valid,
  input wire logic length_ok,
  input wire logic halt_req,
  input wire logic seq_done,
  input wire logic auto_fwd,
  input wire logic auto_slow,
  input wire logic jog_fwd,
  input wire logic jog_rev,
  input wire logic approach_shear,
  output logic out1_q,
  output logic out2_q,
  output logic rev_q,
  output logic running_q,
  output logic cfg_invalid_q,
  output logic cfg_ready_q,
  output logic [1:0] speed_mode_q,
  output logic [1:0] mach_type_q,
  output logic remote_mode_q,
  output logic shear_flying_q,
  output logic shear_boost_q,
  output logic shear_two_speed_q,
  output logic manual_shear_block_q,
  output logic single_batch_q,
  output logic punch_flying_q,
  output logic punch_boost_q,
  output logic punch_two_speed_q,
  output logic boost_params_q
);
  cfg_if cfg ();
  logic running;
  logic [1:0] run_st;
  logic fwd;
  logic rev;
  logic moving;
  logic slow_need;
  logic jogging;
  logic out1_d;
  logic out2_d;
  logic rev_d;
  logic motion_ok;
  cut_line_pkg::speed_mode_t mode;

  // =========================================
  // configuration capture
  cfg_sample u_cfg (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cfg_sw(cfg_sw),
    .opt_strap(opt_strap),
    .cfg(cfg.src)
  );

  // =========================================
  // start control
  run_start #(
    .ILK_WIN_CYC(ILK_WIN_CYC)
  ) u_run (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .cfg(cfg.dst),
    .run_press(run_press),
    .in3_closed(in3_closed),
    .job_valid(job_valid),
    .length_ok(length_ok),
    .halt_req(halt_req),
    .seq_done(seq_done),
    .running(running),
    .state(run_st)
  );

  // =========================================
  // movement requests
  // jogging is only honoured while the automatic sequence is not running
  assign jogging = ~running & (jog_fwd ^ jog_rev);
  assign fwd = (running & auto_fwd) | (jogging & jog_fwd);
  assign rev = jogging & jog_rev;
  assign moving = fwd | rev;
  // two-speed shear on the option variants forces slow on the shear approach
  assign slow_need = auto_slow | (cfg.shear_two_speed & approach_shear) | jogging;
  assign motion_ok = cfg.valid & (cfg.speed_mode != cut_line_pkg::SPD_INVALID);

  // option variants: one speed runs single logic, two speed runs fwd-slow logic
  always_comb begin
    mode = cfg.speed_mode;
    if (cfg.opt_variant) begin
      mode = cfg.shear_two_speed ? cut_line_pkg::SPD_FWD_SLOW : cut_line_pkg::SPD_SINGLE;
    end
  end

  // =========================================
  // speed output logic
  always_comb begin
    out1_d = 1'b0;
    out2_d = 1'b0;
    rev_d = 1'b0;
    if (motion_ok) begin
      case (mode)
        cut_line_pkg::SPD_SINGLE: begin
          out1_d = fwd;
          rev_d = rev;
          out2_d = ~moving | jogging;
        end
        cut_line_pkg::SPD_FWD_SLOW: begin
          out1_d = fwd;
          rev_d = rev;
          out2_d = ~fwd | slow_need;
        end
        cut_line_pkg::SPD_FAST_SLOW: begin
          out1_d = fwd & ~slow_need;
          out2_d = fwd & slow_need;
          rev_d = rev;
        end
        default: begin
          out1_d = 1'b0;
          out2_d = 1'b0;
          rev_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out1_q <= 1'b0;
      out2_q <= 1'b0;
      rev_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      out1_q <= out1_d;
      out2_q <= out2_d;
      rev_q <= rev_d;
      running_q <= running;
    end
  end

  // =========================================
  // decoded configuration outputs
  // these only change on the capture edge, so registering costs one cycle of latency
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ready_q <= 1'b0;
      cfg_invalid_q <= 1'b0;
      speed_mode_q <= 2'h0;
      mach_type_q <= 2'h0;
      remote_mode_q <= 1'b0;
      shear_flying_q <= 1'b0;
      shear_boost_q <= 1'b0;
      shear_two_speed_q <= 1'b0;
      manual_shear_block_q <= 1'b0;
      single_batch_q <= 1'b0;
      punch_flying_q <= 1'b0;
      punch_boost_q <= 1'b0;
      punch_two_speed_q <= 1'b0;
      boost_params_q <= 1'b0;
    end else begin
      cfg_ready_q <= cfg.valid;
      cfg_invalid_q <= cfg.valid & (cfg.speed_mode == cut_line_pkg::SPD_INVALID);
      speed_mode_q <= mode;
      mach_type_q <= cfg.opt_variant ? 2'h0 : cfg.mach_type;
      remote_mode_q <= cfg.remote_mode;
      shear_flying_q <= cfg.shear_flying;
      shear_boost_q <= cfg.shear_boost;
      shear_two_speed_q <= cfg.shear_two_speed;
      manual_shear_block_q <= cfg.manual_shear_block;
      single_batch_q <= cfg.single_batch;
      punch_flying_q <= cfg.punch_flying;
      punch_boost_q <= cfg.punch_boost;
      punch_two_speed_q <= cfg.punch_two_speed;
      // die boost parameters only offered where the type has a boost
      boost_params_q <= cfg.valid & (cfg.opt_variant ? cfg.shear_boost
        : cfg.mach_type == cut_line_pkg::MT_FLY_BOOST);
    end
  end

  // =========================================
  // checks
  fs_exclusive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    speed_mode_q == 2'h2 && cfg_ready_q |-> !(out1_q && out2_q))
    else $error("fast and slow both on");
  fwdslow_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode == cut_line_pkg::SPD_FWD_SLOW && motion_ok) && !out1_q |-> out2_q)
    else $error("slow off while forward off");
  single_halt_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(mode == cut_line_pkg::SPD_SINGLE && motion_ok) && !out1_q && !rev_q |-> out2_q)
    else $error("single speed halted without slow");
  invalid_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_invalid_q |-> !out1_q && !out2_q && !rev_q && !running_q)
    else $error("motion with invalid configuration");
  fwd_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == cut_line_pkg::SPD_FWD_SLOW && motion_ok && running && auto_fwd |=> out1_q)
    else $error("forward not driven in automatic run");
  fs_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == cut_line_pkg::SPD_FAST_SLOW && !fwd |=> !out1_q && !out2_q)
    else $error("fast-slow output on while stopped");
  mode_frozen_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_ready_q ##1 cfg_ready_q |-> $stable(speed_mode_q) && $stable(remote_mode_q))
    else $error("decoded mode changed after capture");
  run_lag_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    run_st == 2'h2 |=> running_q)
    else $error("running output missed the sequencer");
  single_rev_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == cut_line_pkg::SPD_SINGLE && motion_ok && rev |=> rev_q && !out1_q)
    else $error("single speed reverse not driven alone");
  single_jog_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == cut_line_pkg::SPD_SINGLE && motion_ok && jogging |=> out2_q)
    else $error("single speed jog without slow");
  fwdslow_feed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == cut_line_pkg::SPD_FWD_SLOW && motion_ok && fwd && slow_need |=> out1_q && out2_q)
    else $error("slow feed not selected");
  fast_move_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == cut_line_pkg::SPD_FAST_SLOW && motion_ok && fwd && !slow_need |=> out1_q && !out2_q)
    else $error("fast movement not on fast output");
  slow_move_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    mode == cut_line_pkg::SPD_FAST_SLOW && motion_ok && fwd && slow_need |=> !out1_q && out2_q)
    else $error("slow movement not on slow output");
  approach_slow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    motion_ok && cfg.shear_two_speed && approach_shear |=> out2_q)
    else $error("shear approach not slowed");
  jog_locked_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    running |=> !rev_q)
    else $error("reverse driven during automatic run");
  not_ready_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !cfg_ready_q |-> !out1_q && !out2_q && !rev_q && !running_q)
    else $error("motion before configuration capture");
  invalid_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_invalid_q |-> speed_mode_q == 2'h3 && !cfg.opt_variant)
    else $error("invalid flag without invalid basic setting");
  opt_decode_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_ready_q && cfg.opt_variant |-> speed_mode_q == {1'b0, cfg.shear_two_speed} && mach_type_q == 2'h0)
    else $error("option variant speed logic wrong");
  boost_param_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_ready_q && !cfg.opt_variant && mach_type_q != 2'h0 |-> !boost_params_q)
    else $error("boost parameters offered without boost type");
endmodule : cut_line_speed_run_config
`default_nettype wire

// >>> verification/valve_model.sv
// hydraulic valve pair driven by the two speed outputs
`timescale 1ns/1ps
`default_nettype none
// =========================================
// valve pair
module valve_model (
  input wire logic fast_slow,
  input wire logic out1,
  input wire logic out2,
  output logic [1:0] flow
);
  // flow: 0 stopped, 1 slow, 2 fast, 3 both valves open
  always_comb begin
    if (fast_slow) begin
      // parallel valves: each one owns a speed
      flow = {out1, out2};
    end else begin
      // series valves: forward opens oil, slow limits it
      flow = out1 ? (out2 ? 2'h1 : 2'h2) : 2'h0;
    end
  end
endmodule : valve_model
`default_nettype wire

// >>> verification/test_cut_line_speed_run_config.sv
// self-checking bench for the cut line speed and run configuration block
`timescale 1ns/1ps
`default_nettype none
module test_cut_line_speed_run_config;
  // short interlock window keeps the run brief
  localparam int unsigned WIN = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] cfg_sw = 7'h00;
  logic opt_strap = 1'b0, run_press = 1'b0, in3_closed = 1'b0, job_valid = 1'b0, length_ok = 1'b0;
  logic halt_req = 1'b0, seq_done = 1'b0, auto_fwd = 1'b0, auto_slow = 1'b0, jog_fwd = 1'b0;
  logic jog_rev = 1'b0, approach_shear = 1'b0;
  logic out1_q, out2_q, rev_q, running_q, cfg_invalid_q, cfg_ready_q, remote_mode_q, shear_flying_q;
  logic shear_boost_q, shear_two_speed_q, manual_shear_block_q, single_batch_q, punch_flying_q;
  logic punch_boost_q, punch_two_speed_q, boost_params_q;
  logic [1:0] speed_mode_q, mach_type_q, flow;
  int num_errors = 0;
  int tests_run = 0;
  // =========================================
  // design, valve model and clock
  cut_line_speed_run_config #(.ILK_WIN_CYC(WIN)) uut (
    .core_clk, .rst_n, .cfg_sw, .opt_strap, .run_press, .in3_closed, .job_valid, .length_ok,
    .halt_req, .seq_done, .auto_fwd, .auto_slow, .jog_fwd, .jog_rev, .approach_shear, .out1_q,
    .out2_q, .rev_q, .running_q, .cfg_invalid_q, .cfg_ready_q, .speed_mode_q, .mach_type_q,
    .remote_mode_q, .shear_flying_q, .shear_boost_q, .shear_two_speed_q, .manual_shear_block_q,
    .single_batch_q, .punch_flying_q, .punch_boost_q, .punch_two_speed_q, .boost_params_q
  );
  valve_model valves (.fast_slow(speed_mode_q === 2'h2), .out1(out1_q), .out2(out2_q), .flow(flow));
  always #5 core_clk = ~core_clk;
  // =========================================
  // shared tasks
  task automatic cmp(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic do_reset(input logic [6:0] sw, input logic strap);
    rst_n = 1'b0;
    cfg_sw = sw;
    opt_strap = strap;
    {run_press, in3_closed, job_valid, length_ok, halt_req, seq_done} = 6'h00;
    {auto_fwd, auto_slow, jog_fwd, jog_rev, approach_shear} = 5'h00;
    tick(3);
    cmp(cfg_ready_q, 1'b0);
    cmp(out2_q, 1'b0);
    rst_n = 1'b1;
    tick(3);
  endtask : do_reset
  // polls a bounded number of cycles for a start, or waits them all for no start
  task automatic wait_run(input logic exp, input int n);
    int i;
    if (!exp) tick(n);
    for (i = 0; i < n && running_q !== exp; i++) tick(1);
    cmp(running_q, exp);
  endtask : wait_run
  task automatic end_sim();
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // =========================================
  // scenarios
  task automatic t_speed();
    for (int m = 0; m < 4; m++) begin
      do_reset({5'h00, 2'(m)}, 1'b0);
      cmp(speed_mode_q, 7'(m));
      cmp(cfg_invalid_q, m == 3);
      cmp(out2_q, m < 2);
      cmp(out1_q, 1'b0);
      jog_fwd = 1'b1;
      tick(2);
      cmp(out1_q, m < 2);
      cmp(out2_q, m != 3);
      cmp(flow, (m == 3) ? 7'h0 : 7'h1);
      jog_fwd = 1'b0;
      jog_rev = 1'b1;
      tick(2);
      cmp(rev_q, m != 3);
      cmp(out1_q, 1'b0);
      jog_rev = 1'b0;
    end
    $display("test speed done");
  endtask : t_speed
  task automatic t_basic_flags();
    do_reset(7'h6C, 1'b0);
    cmp({remote_mode_q, manual_shear_block_q, single_batch_q}, 7'h7);
    for (int k = 0; k < 4; k++) begin
      do_reset(7'({k, 3'h0}), 1'b0);
      cmp(mach_type_q, 7'(k));
      cmp(remote_mode_q, 1'b0);
      cmp(boost_params_q, k == 0);
    end
    // late switch moves must not reach the decoded outputs
    cfg_sw = 7'h07;
    tick(4);
    cmp({speed_mode_q, mach_type_q, remote_mode_q}, 7'h06);
    $display("test basic flags done");
  endtask : t_basic_flags
  task automatic t_option();
    logic [6:0] vals [3] = '{7'h55, 7'h2A, 7'h03};
    foreach (vals[i]) begin
      do_reset(vals[i], 1'b1);
      cmp({shear_flying_q, shear_boost_q}, {vals[i][0], !vals[i][1]});
      cmp({shear_two_speed_q, remote_mode_q}, {vals[i][2], vals[i][3]});
      cmp({punch_flying_q, punch_boost_q, punch_two_speed_q}, {vals[i][4], !vals[i][5], vals[i][6]});
      cmp({cfg_invalid_q, mach_type_q}, 7'h0);
      cmp({speed_mode_q, boost_params_q}, {vals[i][2], !vals[i][1]});
    end
    // two-speed shear runs forward-slow logic and slows on the approach
    do_reset(7'h05, 1'b1);
    {in3_closed, job_valid, length_ok, run_press} = 4'hF;
    wait_run(1'b1, 4);
    {run_press, auto_fwd} = 2'h1;
    tick(2);
    cmp({out1_q, out2_q, flow}, 7'hA);
    approach_shear = 1'b1;
    tick(2);
    cmp({out1_q, out2_q, flow}, 7'hD);
    seq_done = 1'b1;
    wait_run(1'b0, 4);
    $display("test option done");
  endtask : t_option
  task automatic t_local();
    do_reset(7'h01, 1'b0);
    {in3_closed, length_ok, run_press} = 3'h7;
    wait_run(1'b0, 6);
    {job_valid, length_ok} = 2'h2;
    wait_run(1'b0, 6);
    {run_press, length_ok} = 2'h1;
    wait_run(1'b0, 6);
    run_press = 1'b1;
    wait_run(1'b1, 4);
    run_press = 1'b0;
    auto_fwd = 1'b1;
    tick(2);
    cmp({out1_q, out2_q, flow}, 7'hA);
    auto_slow = 1'b1;
    tick(2);
    cmp({out1_q, out2_q, flow}, 7'hD);
    halt_req = 1'b1;
    wait_run(1'b0, 4);
    cmp({out1_q, out2_q}, 7'h1);
    {halt_req, auto_fwd, auto_slow, in3_closed, run_press} = 5'h01;
    tick(2);
    run_press = 1'b0;
    tick(8);
    in3_closed = 1'b1;
    wait_run(1'b1, 4);
    in3_closed = 1'b0;
    wait_run(1'b0, 4);
    // last edge of the window still accepts the interlock
    run_press = 1'b1;
    tick(2);
    run_press = 1'b0;
    tick(WIN - 2);
    in3_closed = 1'b1;
    wait_run(1'b1, 4);
    in3_closed = 1'b0;
    wait_run(1'b0, 4);
    // one edge later the press has lapsed
    run_press = 1'b1;
    tick(2);
    run_press = 1'b0;
    tick(WIN - 1);
    in3_closed = 1'b1;
    wait_run(1'b0, 6);
    $display("test local done");
  endtask : t_local
  task automatic t_remote();
    do_reset(7'h04, 1'b0);
    {job_valid, length_ok, run_press} = 3'h7;
    wait_run(1'b0, 6);
    {run_press, in3_closed, auto_fwd} = 3'h3;
    wait_run(1'b1, 4);
    tick(2);
    cmp({out1_q, out2_q, rev_q}, 7'h4);
    in3_closed = 1'b0;
    wait_run(1'b0, 4);
    auto_fwd = 1'b0;
    $display("test remote done");
  endtask : t_remote
  task automatic t_fast_slow();
    do_reset(7'h02, 1'b0);
    {in3_closed, job_valid, length_ok, run_press} = 4'hF;
    wait_run(1'b1, 4);
    {run_press, auto_fwd} = 2'h1;
    tick(2);
    cmp({out1_q, out2_q, flow}, 7'hA);
    auto_slow = 1'b1;
    tick(2);
    cmp({out1_q, out2_q, flow}, 7'h5);
    auto_fwd = 1'b0;
    tick(2);
    cmp({out1_q, out2_q, flow}, 7'h0);
    $display("test fast slow done");
  endtask : t_fast_slow
  // =========================================
  // main sequence and watchdog
  initial begin
    t_speed();
    t_basic_flags();
    t_option();
    t_local();
    t_remote();
    t_fast_slow();
    end_sim();
  end
  initial begin
    // roughly ten times the expected run length
    #30000;
    num_errors++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : test_cut_line_speed_run_config
`default_nettype wire
